//--- ivp_pkg.sv
// constants and types shared by the interrupt vector and priority map
package ivp_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_REQ    = 24;
  localparam int unsigned NUM_LVLREG = 6;
  localparam int unsigned LVL_W      = 2;
  localparam int unsigned NUM_W      = 5;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_LVL0   = 10'h079;   // level_setting_reg0
  localparam logic [9:0] IDX_LVL5   = 10'h07e;   // level_setting_reg5
  localparam logic [9:0] IDX_STATUS = 10'h080;   // sticky pending bits, write one to clear
  localparam logic [9:0] IDX_MASK   = 10'h081;   // request enables
  localparam logic [9:0] IDX_SEL    = 10'h082;   // selected request, read only

  // ==========================================================
  // field positions of the selected request register
  localparam int unsigned SEL_NUM_LSB   = 0;
  localparam int unsigned SEL_LVL_LSB   = 8;
  localparam int unsigned SEL_VALID_BIT = 16;

  // ==========================================================
  // reset values
  localparam logic [7:0]  LVL_RST    = 8'hff;
  localparam logic [23:0] STATUS_RST = 24'h000000;
  localparam logic [23:0] MASK_RST   = 24'h000000;

  // ==========================================================
  // vector table, request 0 high byte sits at the top, step two per request
  localparam logic [15:0] VEC_BASE_HI = 16'hfffa;
  localparam logic [15:0] VEC_LO_OFS  = 16'h0001;

  // ==========================================================
  // request numbers with a source
  localparam int unsigned REQ_EXT4   = 0;
  localparam int unsigned REQ_EXT5   = 1;
  localparam int unsigned REQ_EXT26  = 2;
  localparam int unsigned REQ_EXT37  = 3;
  localparam int unsigned REQ_TMR0L  = 5;
  localparam int unsigned REQ_TMR0H  = 6;
  localparam int unsigned REQ_URX    = 7;
  localparam int unsigned REQ_UTX    = 8;
  localparam int unsigned REQ_TMR1H  = 14;
  localparam int unsigned REQ_ADC    = 18;
  localparam int unsigned REQ_TBASE  = 19;
  localparam int unsigned REQ_WATCH  = 20;
  localparam int unsigned REQ_TMR1L  = 22;
  localparam int unsigned REQ_FLASH  = 23;

  // ==========================================================
  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic ext_ch2;
    logic ext_ch3;
    logic ext_ch4;
    logic ext_ch5;
    logic ext_ch6;
    logic ext_ch7;
    logic tmr0_lo;
    logic tmr0_hi;
    logic uart_rx;
    logic uart_tx;
    logic tmr1_hi;
    logic tmr1_lo;
    logic adc;
    logic tbase;
    logic watch;
    logic flash;
  } ivp_src_t;

  // winner of the resolver
  typedef struct packed {
    logic             valid;
    logic [LVL_W-1:0] level;
    logic [NUM_W-1:0] num;
  } ivp_sel_t;

  // answer towards the cpu core
  typedef struct packed {
    logic             irq;
    logic [LVL_W-1:0] level;
    logic [NUM_W-1:0] num;
    logic [15:0]      vec_hi_addr;
    logic [15:0]      vec_lo_addr;
  } ivp_cpu_t;

  // all state of the top module
  typedef struct packed {
    logic [NUM_LVLREG-1:0][7:0] lvl;
    logic [NUM_REQ-1:0]         pend;
    logic [NUM_REQ-1:0]         mask;
    logic [31:0]                rdata;
    logic                       slverr;
    ivp_cpu_t                   cpu;
  } ivp_state_t;

  localparam ivp_cpu_t CPU_RST = '{
    irq:         1'b0,
    level:       2'b11,
    num:         5'h00,
    vec_hi_addr: VEC_BASE_HI,
    vec_lo_addr: 16'hfffb
  };

endpackage

//--- ivp_resolve.sv
// picks the most urgent pending request, lowest number on a tie
module ivp_resolve (
  input  wire logic [ivp_pkg::NUM_REQ-1:0]          pend,
  input  wire logic [ivp_pkg::NUM_REQ*2-1:0]        levels,
  output ivp_pkg::ivp_sel_t                         sel
);

  // ==========================================================
  // scan
  // ascending scan with a strict compare keeps the lower number on a tie
  always_comb
  begin
    sel.valid = 1'b0;
    sel.level = 2'b11;
    sel.num   = 5'h00;
    for (int i = 0; i < ivp_pkg::NUM_REQ; i++)
    begin
      if (pend[i] && (!sel.valid || levels[2*i +: 2] < sel.level))
      begin
        sel.valid = 1'b1;
        sel.level = levels[2*i +: 2];
        sel.num   = 5'(i);
      end
    end
  end

endmodule

//--- ivp_top.sv
// interrupt vector and priority map with apb register access
//
// Behaviour
// - each request has its own two-bit level
// - equal levels: lower request number served first
// - vector pair from FFFA/FFFB, two lower each
// - full variant: channels 2/6 and 3/7 share
// - full variant: serial receive 7, transmit 8
// - timer 0 lower half 5, upper 6
// - converter 18, time-base 19, watch 20, flash 23
// - channel 4 request 0; reduced: unlisted lines idle
// - six level registers at 0079 to 007E
// - level registers reset to all ones
//
// The placing of the registers and the APB slave port were left to the implementer.
module ivp_top #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // peripheral events
  input  ivp_pkg::ivp_src_t         src,
  // cpu side
  input  wire logic                 cpu_ack,
  output ivp_pkg::ivp_cpu_t         cpu,
  output logic                      irq
);

  // ==========================================================
  // state
  ivp_pkg::ivp_state_t s_q;
  ivp_pkg::ivp_state_t s_d;

  logic [ivp_pkg::NUM_REQ-1:0] req;
  logic [ivp_pkg::NUM_REQ-1:0] clr;
  logic [ivp_pkg::NUM_REQ-1:0] ack_hot;
  logic [9:0]                  idx;
  logic                        setup;
  logic                        wr;
  logic                        lvl_hit;
  logic [2:0]                  lvl_sel;
  logic [31:0]                 rd_val;
  logic                        rd_err;
  ivp_pkg::ivp_sel_t           win;
  ivp_pkg::ivp_sel_t           win_hold;
  logic [15:0]                 vec_hi;

  // ==========================================================
  // source to request mapping
  // unlisted request lines stay low in either variant
  always_comb
  begin
    req = '0;
    req[ivp_pkg::REQ_EXT4]  = src.ext_ch4;
    req[ivp_pkg::REQ_EXT5]  = FULL_VARIANT & src.ext_ch5;
    req[ivp_pkg::REQ_EXT26] = src.ext_ch6 | (FULL_VARIANT & src.ext_ch2);
    req[ivp_pkg::REQ_EXT37] = FULL_VARIANT & (src.ext_ch3 | src.ext_ch7);
    req[ivp_pkg::REQ_TMR0L] = src.tmr0_lo;
    req[ivp_pkg::REQ_TMR0H] = src.tmr0_hi;
    req[ivp_pkg::REQ_URX]   = FULL_VARIANT & src.uart_rx;
    req[ivp_pkg::REQ_UTX]   = FULL_VARIANT & src.uart_tx;
    req[ivp_pkg::REQ_TMR1H] = FULL_VARIANT & src.tmr1_hi;
    req[ivp_pkg::REQ_ADC]   = src.adc;
    req[ivp_pkg::REQ_TBASE] = src.tbase;
    req[ivp_pkg::REQ_WATCH] = src.watch;
    req[ivp_pkg::REQ_TMR1L] = FULL_VARIANT & src.tmr1_lo;
    req[ivp_pkg::REQ_FLASH] = src.flash;
  end

  // ==========================================================
  // priority resolution over enabled pending requests
  ivp_resolve u_resolve (
    .pend   (s_q.pend & s_q.mask),
    .levels (s_q.lvl),
    .sel    (win)
  );

  // ==========================================================
  // apb decode
  // zero wait states; read data is captured in the setup cycle
  assign idx     = paddr[11:2];
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign lvl_hit = (idx >= ivp_pkg::IDX_LVL0) && (idx <= ivp_pkg::IDX_LVL5);
  assign lvl_sel = 3'(idx - ivp_pkg::IDX_LVL0);
  assign pready  = 1'b1;

  // read multiplexer, unmapped words read zero with an error
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (lvl_hit)
    begin
      rd_val[7:0] = s_q.lvl[lvl_sel];
    end
    else
    begin
      case (idx)
        ivp_pkg::IDX_STATUS: rd_val[23:0] = s_q.pend;
        ivp_pkg::IDX_MASK:   rd_val[23:0] = s_q.mask;
        ivp_pkg::IDX_SEL:
        begin
          rd_val[ivp_pkg::SEL_NUM_LSB +: 5] = s_q.cpu.num;
          rd_val[ivp_pkg::SEL_LVL_LSB +: 2] = s_q.cpu.level;
          rd_val[ivp_pkg::SEL_VALID_BIT]    = s_q.cpu.irq;
        end
        default:             rd_err = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // clear terms for the pending bits
  // the cpu acknowledge drops the request it is being served
  always_comb
  begin
    ack_hot = '0;
    if (cpu_ack && s_q.cpu.irq)
    begin
      ack_hot[s_q.cpu.num] = 1'b1;
    end
    clr = ack_hot;
    if (wr && idx == ivp_pkg::IDX_STATUS)
    begin
      clr = clr | pwdata[23:0];
    end
  end

  // ==========================================================
  // vector address of the winner
  // the pair follows the winner, so a fetch that races a new winner sees the new pair
  assign win_hold = win;
  assign vec_hi   = ivp_pkg::VEC_BASE_HI - {10'h000, win_hold.num, 1'b0};

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;

    // set wins over clear so an event in the clearing cycle stays
    s_d.pend = (s_q.pend & ~clr) | req;

    if (wr && idx == ivp_pkg::IDX_MASK)
    begin
      s_d.mask = pwdata[23:0];
    end

    // full-byte writes, each byte holds four level fields
    if (wr && lvl_hit)
    begin
      s_d.lvl[lvl_sel] = pwdata[7:0];
    end

    if (setup)
    begin
      s_d.rdata  = rd_val;
      s_d.slverr = rd_err;
    end

    // answer to the cpu follows the resolver one cycle later
    s_d.cpu.irq         = win.valid;
    s_d.cpu.level       = win.level;
    s_d.cpu.num         = win.num;
    s_d.cpu.vec_hi_addr = vec_hi;
    s_d.cpu.vec_lo_addr = vec_hi + ivp_pkg::VEC_LO_OFS;
    if (!win.valid)
    begin
      s_d.cpu = ivp_pkg::CPU_RST;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.lvl    <= {ivp_pkg::NUM_LVLREG{ivp_pkg::LVL_RST}};
      s_q.pend   <= ivp_pkg::STATUS_RST;
      s_q.mask   <= ivp_pkg::MASK_RST;
      s_q.rdata  <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
      s_q.cpu    <= ivp_pkg::CPU_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.slverr & psel & penable;
  assign cpu     = s_q.cpu;
  assign irq     = s_q.cpu.irq;

endmodule

//--- ivp_cpu_model.sv
// behavioural cpu core that fetches vectors and acknowledges them
module ivp_cpu_model (
  input  wire logic        pclk,
  input  wire logic        en,
  input  wire logic [3:0]  dly,
  input  ivp_pkg::ivp_cpu_t cpu,
  output logic             cpu_ack,
  output ivp_pkg::ivp_cpu_t last,
  output int               n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cpu_ack = 1'b0;
  initial n = 0;
  // ==========================================================
  // fetch: wait dly cycles, ack one cycle, then let the pipe settle
  // the two idle cycles avoid acking the stale winner a second time
  always @(posedge pclk)
    if (en && cpu.irq)
    begin
      repeat (dly) @(posedge pclk);
      cpu_ack <= 1'b1;
      @(posedge pclk);
      cpu_ack <= 1'b0;
      last <= cpu;
      n <= n + 1;
      repeat (2) @(posedge pclk);
    end
endmodule

//--- ivp_top_properties.sv
// assertion checker for the interrupt vector and priority map
module ivp_top_properties #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic [11:0]  paddr,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input ivp_pkg::ivp_src_t src,
  input wire logic         cpu_ack,
  input ivp_pkg::ivp_cpu_t cpu,
  input wire logic         irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // vector and source checks
  vec_base_a: assert property (cpu.irq |-> cpu.vec_hi_addr == 16'hfffa - {cpu.num, 1'b0})
    else $error("vector high address wrong");
  vec_pair_a: assert property (cpu.irq |-> cpu.vec_lo_addr == cpu.vec_hi_addr + 16'h0001)
    else $error("vector low address wrong");
  idle_req_a: assert property (cpu.irq |-> cpu.num <= 5'h17 &&
    !(cpu.num inside {5'h04, [5'h09:5'h0d], [5'h0f:5'h11], 5'h15}))
    else $error("request without source shown");
  reduced_req_a: assert property (!FULL_VARIANT && cpu.irq |->
    cpu.num inside {5'h00, 5'h02, 5'h05, 5'h06, [5'h12:5'h14], 5'h17})
    else $error("reduced variant shows foreign request");
  // quiet inputs for three cycles leave the answer frozen
  hold_out_a: assert property ((src == '0 && !psel && !cpu_ack) [*3] |=> $stable(cpu))
    else $error("cpu outputs moved without cause");
  irq_mirror_a: assert property (irq == cpu.irq)
    else $error("irq differs from cpu request flag");
  idle_out_a: assert property (!cpu.irq |-> cpu.level == 2'b11 && cpu.num == 5'h00 &&
    cpu.vec_hi_addr == 16'hfffa && cpu.vec_lo_addr == 16'hfffb)
    else $error("idle cpu answer not at rest value");
  // ==========================================================
  // register bus checks
  lvl_read_a: assert property (psel && penable && !pwrite && paddr[11:2] inside {[10'h079:10'h07e]}
    |-> prdata[31:8] == 24'h0 && !pslverr)
    else $error("level register read wrong");
  unmapped_a: assert property (psel && penable &&
    !(paddr[11:2] inside {[10'h079:10'h07e], [10'h080:10'h082]}) |-> pslverr)
    else $error("unmapped access not refused");
  slverr_when_a: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");
endmodule

bind ivp_top ivp_top_properties #(.FULL_VARIANT(FULL_VARIANT)) chk (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .src, .cpu_ack, .cpu, .irq);

//--- ivp_top_test.sv
// self-checking bench for the interrupt vector and priority map
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, g, e); end end
module ivp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, en = 0;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, prdata_r;
  logic              pready, pslverr, irq, cpu_ack;
  logic [3:0]        dly = '0;
  ivp_pkg::ivp_src_t src = '0;
  ivp_pkg::ivp_cpu_t cpu, last;
  int                errors = 0, n_tests = 0, n, i;
  int unsigned       m [16] = '{2, 3, 0, 1, 2, 3, 5, 6, 7, 8, 14, 22, 18, 19, 20, 23};

  always #2.5 pclk = ~pclk;

  ivp_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .src, .cpu_ack, .cpu, .irq);
  ivp_cpu_model cpu_m (.pclk, .en, .dly, .cpu, .cpu_ack, .last, .n);
  // reduced variant on the same bus and events, never acknowledged
  ivp_top #(.FULL_VARIANT(1'b0)) uut_r (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata(prdata_r), .pready(), .pslverr(), .src, .cpu_ack(1'b0), .cpu(), .irq());

  // ==========================================================
  // apb transfer, waits for pready, takes data at that edge
  task automatic xfer(input logic [9:0] x, input logic w, input logic [31:0] d, input logic err = 1'b0);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= {x, 2'b00};
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed, only the watchdog ends a hung access
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    `CHK(pslverr, err)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [15:0] s);
    @(posedge pclk);
    src <= s;
    @(posedge pclk);
    src <= '0;
  endtask

  // waits for the cpu model to fetch, then checks the fetched vector
  task automatic serve(input int unsigned e);
    int k, t;
    k = n;
    t = 0;
    while (n == k && t < 200)
    begin
      @(posedge pclk);
      t++;
    end
    `CHK(n == k, 1'b0)
    `CHK(last.num, 5'(e))
    `CHK(last.vec_hi_addr, 16'(16'hfffa - 2 * e))
    `CHK(last.vec_lo_addr, 16'(16'hfffb - 2 * e))
  endtask

  task automatic conclude;
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    errors++;
    conclude();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      xfer(10'(10'h079 + i), 1'b0, '0);
      `CHK(rd, 32'h0000_00ff)
      xfer(10'(10'h079 + i), 1'b1, 32'hffff_ff00 | i);
      xfer(10'(10'h079 + i), 1'b0, '0);
      `CHK(rd, 32'(i))
      xfer(10'(10'h079 + i), 1'b1, 32'h0000_00ff);
    end
    xfer(10'h07f, 1'b0, '0, 1'b1);
    `CHK(rd, 32'h0)
    // masked event stays pending and quiet
    pulse(16'h0008);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    xfer(10'h080, 1'b0, '0);
    `CHK(rd, 32'h0004_0000)
    xfer(10'h081, 1'b1, 32'h0004_0000);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    xfer(10'h082, 1'b0, '0);
    `CHK(rd, 32'h0001_0312)
    xfer(10'h080, 1'b1, 32'h0004_0000);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    // every source to its request, prompt and slow fetches
    xfer(10'h081, 1'b1, 32'h00ff_ffff);
    en <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      dly <= 4'(i);
      pulse(16'h8000 >> i);
      serve(m[i]);
    end
    // every served request is gone; the reduced copy kept only its listed lines
    xfer(10'h080, 1'b0, '0);
    `CHK(rd, 32'h0000_0000)
    `CHK(prdata_r, 32'h009c_0065)
    dly <= 4'h0;
    pulse(16'h200d);
    serve(0);
    serve(18);
    serve(19);
    serve(23);
    xfer(10'h07e, 1'b1, 32'h0000_003f);
    pulse(16'h2001);
    serve(23);
    `CHK(last.level, 2'b00)
    serve(0);
    conclude();
  end
endmodule
